//--- shared/mmu_defines.svh
// Register offsets, field positions, reset values and codes of the MMU block
`ifndef MMU_DEFINES_SVH
`define MMU_DEFINES_SVH

// ----------------------------------------------------------------------
// Register byte offsets (word-aligned APB byte addresses)
// ----------------------------------------------------------------------
`define MMU_OFF_CTRL 8'h00
`define MMU_OFF_PAGE_ENTRY_HIGH_REG 8'h04
`define MMU_OFF_PAGE_ENTRY_LOW_REG 8'h08
`define MMU_OFF_TEA 8'h0c
`define MMU_OFF_EXCEPTION_EVENT_REG 8'h10
`define MMU_OFF_SPC 8'h14
`define MMU_OFF_SSR 8'h18
`define MMU_OFF_VBR 8'h1c
`define MMU_OFF_SR 8'h20
`define MMU_OFF_LOAD 8'h24
`define MMU_OFF_ARR_SEL 8'h28
`define MMU_OFF_ARR_ADDR 8'h2c
`define MMU_OFF_ARR_DATA 8'h30

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define MMU_CTRL_AT 0
`define MMU_CTRL_IX 1
`define MMU_CTRL_TF 2
`define MMU_CTRL_RC_LO 4
`define MMU_CTRL_RC_HI 5
`define MMU_CTRL_SV 8

// ----------------------------------------------------------------------
// Status register fields and reset values
// ----------------------------------------------------------------------
`define MMU_SR_MD 30
`define MMU_SR_RB 29
`define MMU_SR_BL 28
`define MMU_SR_RESET 32'h70000000
`define MMU_ENTRY_FLAG_MASK 32'h0000017e

// ----------------------------------------------------------------------
// Page entry fields
// ----------------------------------------------------------------------
`define MMU_PTE_V 8
`define MMU_LOAD_GO 0

// ----------------------------------------------------------------------
// Exception codes and handler offsets
// ----------------------------------------------------------------------
`define MMU_CODE_MISS_LD 12'h040
`define MMU_CODE_MISS_ST 12'h060
`define MMU_CODE_PROT_LD 12'h0a0
`define MMU_CODE_PROT_ST 12'h0c0
`define MMU_CODE_FIRST_WR 12'h080
`define MMU_VEC_MISS 32'h00000400
`define MMU_VEC_OTHER 32'h00000100

`endif

//--- shared/mmu_pkg.sv
// Types shared by the MMU block and its bench
`default_nettype none
package mmu_pkg;

	// Exception kinds reported to the core
	typedef enum logic [2:0] {
		exc_none,
		exc_tlb_miss,
		exc_protect,
		exc_invalid,
		exc_first_write
	} exc_kind_e;

	// Address half of a TLB entry
	typedef struct packed {
		logic [21:0] virtual_page_number;
		logic [7:0] space_identifier;
	} tlb_tag_s;

	// Data half of a TLB entry
	typedef struct packed {
		logic [21:0] physical_page_number;
		logic [1:0] pr;
		logic sz;
		logic c;
		logic d;
		logic sh;
	} tlb_data_s;

	// Access request from the core
	typedef struct packed {
		logic valid;
		logic write;
		logic [31:0] vaddr;
		logic [31:0] pc;
		logic delay_slot;
		logic [31:0] branch_pc;
	} cpu_req_s;

	// Answer to the core, one cycle after the request
	typedef struct packed {
		logic valid;
		logic [31:0] paddr;
		logic cacheable;
		exc_kind_e exc;
		logic [31:0] vector;
	} cpu_rsp_s;

	// Register state of the block, apart from the TLB entry bodies
	typedef struct packed {
		logic at;
		logic ix;
		logic sv;
		logic [1:0] rc;
		logic [31:0] page_entry_high_reg;
		logic [31:0] page_entry_low_reg;
		logic [31:0] fault_address_reg;
		logic [11:0] exception_event_reg;
		logic [31:0] saved_pc_reg;
		logic [31:0] saved_status_reg;
		logic [31:0] vector_base_reg;
		logic [31:0] sr;
		logic [6:0] arr_sel;
		logic [3:0][31:0] valid;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		cpu_rsp_s rsp;
	} state_s;

endpackage : mmu_pkg
`default_nettype wire

//--- hdl/mmu_tlb.sv
// MMU control: TLB lookup, load-TLB, exception sequences, APB registers
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
`include "mmu_defines.svh"
`default_nettype none

module mmu_tlb (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire mmu_pkg::cpu_req_s cpu_req,
	output mmu_pkg::cpu_rsp_s cpu_rsp,
	output logic [31:0] status_reg
);

	// ------------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------------
	// Entry bodies need no reset: the valid flags in the state guard them
	mmu_pkg::tlb_tag_s tag_mem [4][32];
	mmu_pkg::tlb_data_s data_mem [4][32];
	mmu_pkg::state_s state_q;
	mmu_pkg::state_s state_d;

	logic tag_we;
	logic data_we;
	logic [1:0] mem_way;
	logic [4:0] mem_idx;
	mmu_pkg::tlb_tag_s new_tag;
	mmu_pkg::tlb_data_s new_data;

	// ------------------------------------------------------------------
	// Lookup of the core's access
	// ------------------------------------------------------------------
	logic [4:0] look_idx;
	logic [3:0] match;
	logic [3:0] way_valid;
	logic any_match;
	logic [1:0] hit_way;
	logic privileged;
	mmu_pkg::tlb_data_s hit_data;

	assign privileged = state_q.sr[`MMU_SR_MD];

	// Index from the access address, hashed with the current identifier
	always_comb begin
		look_idx = cpu_req.vaddr[16:12];
		if (state_q.ix) begin
			look_idx = cpu_req.vaddr[16:12] ^ state_q.page_entry_high_reg[4:0];
		end
	end

	// All four ways compared in parallel
	always_comb begin
		for (int w = 0; w < 4; w++) begin
			mmu_pkg::tlb_tag_s t;
			mmu_pkg::tlb_data_s dd;
			t = tag_mem[w][look_idx];
			dd = data_mem[w][look_idx];
			way_valid[w] = state_q.valid[w][look_idx];
			// Bits 11,10 only count for 1-kbyte pages
			// Invalid ways never match, so unwritten bodies cannot fake a hit
			match[w] = way_valid[w] && (t.virtual_page_number[21:2] == cpu_req.vaddr[31:12])
				&& (dd.sz || t.virtual_page_number[1:0] == cpu_req.vaddr[11:10])
				&& (dd.sh || (state_q.sv && privileged)
					|| t.space_identifier == state_q.page_entry_high_reg[7:0]);
		end
	end

	// First matching way wins; software must avoid double hits
	always_comb begin
		any_match = |match;
		hit_way = 2'd0;
		for (int w = 3; w >= 0; w--) begin
			if (match[w]) begin
				hit_way = 2'(w);
			end
		end
		hit_data = data_mem[hit_way][look_idx];
	end

	// ------------------------------------------------------------------
	// Entry writes: load-TLB and the mapped array
	// ------------------------------------------------------------------
	logic bus_wr;
	logic load_go;

	assign bus_wr = psel && penable && state_q.pready && pwrite;
	assign load_go = bus_wr && paddr == `MMU_OFF_LOAD && pwdata[`MMU_LOAD_GO];

	always_comb begin
		tag_we = 1'b0;
		data_we = 1'b0;
		mem_way = state_q.arr_sel[6:5];
		mem_idx = state_q.arr_sel[4:0];
		new_tag = '{virtual_page_number: pwdata[31:10], space_identifier: pwdata[7:0]};
		new_data = mmu_pkg::tlb_data_s'({pwdata[31:10], pwdata[6:5], pwdata[4:1]});
		if (load_go) begin
			tag_we = 1'b1;
			data_we = 1'b1;
			mem_way = state_q.rc;
			mem_idx = state_q.page_entry_high_reg[16:12];
			if (state_q.ix) begin
				mem_idx = state_q.page_entry_high_reg[16:12] ^ state_q.page_entry_high_reg[4:0];
			end
			new_tag = '{virtual_page_number: state_q.page_entry_high_reg[31:10], space_identifier: state_q.page_entry_high_reg[7:0]};
			new_data = mmu_pkg::tlb_data_s'({state_q.page_entry_low_reg[31:10], state_q.page_entry_low_reg[6:1]});
		end else if (bus_wr && paddr == `MMU_OFF_ARR_ADDR) begin
			tag_we = 1'b1;
		end else if (bus_wr && paddr == `MMU_OFF_ARR_DATA) begin
			data_we = 1'b1;
		end
	end

	// Entry bodies
	always_ff @(posedge pclk) begin
		if (tag_we) begin
			tag_mem[mem_way][mem_idx] <= new_tag;
		end
		if (data_we) begin
			data_mem[mem_way][mem_idx] <= new_data;
		end
	end

	// ------------------------------------------------------------------
	// Register read mux
	// ------------------------------------------------------------------
	function automatic logic [31:0] read_reg(input mmu_pkg::state_s s, input logic [7:0] a,
		input mmu_pkg::tlb_tag_s t, input mmu_pkg::tlb_data_s dd);
		logic [31:0] r;
		r = 32'h00000000;
		case (a)
			`MMU_OFF_CTRL: begin
				r[`MMU_CTRL_AT] = s.at;
				r[`MMU_CTRL_IX] = s.ix;
				r[`MMU_CTRL_RC_HI:`MMU_CTRL_RC_LO] = s.rc;
				r[`MMU_CTRL_SV] = s.sv; // Flush bit stays 0
			end
			`MMU_OFF_PAGE_ENTRY_HIGH_REG: r = s.page_entry_high_reg;
			`MMU_OFF_PAGE_ENTRY_LOW_REG: r = s.page_entry_low_reg;
			`MMU_OFF_TEA: r = s.fault_address_reg;
			`MMU_OFF_EXCEPTION_EVENT_REG: r = {20'h00000, s.exception_event_reg};
			`MMU_OFF_SPC: r = s.saved_pc_reg;
			`MMU_OFF_SSR: r = s.saved_status_reg;
			`MMU_OFF_VBR: r = s.vector_base_reg;
			`MMU_OFF_SR: r = s.sr;
			`MMU_OFF_ARR_SEL: r = {25'h0000000, s.arr_sel};
			`MMU_OFF_ARR_ADDR: begin
				r = {t.virtual_page_number, 1'b0, s.valid[s.arr_sel[6:5]][s.arr_sel[4:0]], t.space_identifier};
			end
			`MMU_OFF_ARR_DATA: begin
				r = {dd.physical_page_number, 1'b0, s.valid[s.arr_sel[6:5]][s.arr_sel[4:0]], 1'b0, dd.pr,
					dd.sz, dd.c, dd.d, dd.sh, 1'b0};
			end
			default: r = 32'h00000000;
		endcase
		return r;
	endfunction : read_reg

	function automatic logic mapped(input logic [7:0] a);
		return a[1:0] == 2'b00 && a <= `MMU_OFF_ARR_DATA;
	endfunction : mapped

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		mmu_pkg::exc_kind_e kind;
		logic [1:0] lowest_free;
		state_d = state_q;
		kind = mmu_pkg::exc_none;
		lowest_free = 2'd0;

		// APB: answer one cycle after setup, so every bus output is a flop
		state_d.pready = psel && !penable;
		state_d.pslverr = psel && !penable && !mapped(paddr);
		if (psel && !penable) begin
			state_d.prdata = read_reg(state_q, paddr,
				tag_mem[state_q.arr_sel[6:5]][state_q.arr_sel[4:0]],
				data_mem[state_q.arr_sel[6:5]][state_q.arr_sel[4:0]]);
		end

		// Software writes
		if (bus_wr) begin
			case (paddr)
				`MMU_OFF_CTRL: begin
					state_d.at = pwdata[`MMU_CTRL_AT];
					state_d.ix = pwdata[`MMU_CTRL_IX];
					state_d.sv = pwdata[`MMU_CTRL_SV];
					state_d.rc = pwdata[`MMU_CTRL_RC_HI:`MMU_CTRL_RC_LO];
					if (pwdata[`MMU_CTRL_TF]) begin
						state_d.valid = '0;
					end
				end
				`MMU_OFF_PAGE_ENTRY_HIGH_REG: state_d.page_entry_high_reg = pwdata & 32'hfffffcff;
				`MMU_OFF_PAGE_ENTRY_LOW_REG: state_d.page_entry_low_reg = pwdata & 32'hfffffc00 | pwdata & `MMU_ENTRY_FLAG_MASK;
				`MMU_OFF_TEA: state_d.fault_address_reg = pwdata;
				`MMU_OFF_EXCEPTION_EVENT_REG: state_d.exception_event_reg = pwdata[11:0];
				`MMU_OFF_SPC: state_d.saved_pc_reg = pwdata;
				`MMU_OFF_SSR: state_d.saved_status_reg = pwdata;
				`MMU_OFF_VBR: state_d.vector_base_reg = pwdata;
				`MMU_OFF_SR: state_d.sr = pwdata;
				`MMU_OFF_ARR_SEL: state_d.arr_sel = pwdata[6:0];
				`MMU_OFF_ARR_ADDR: begin
					state_d.valid[state_q.arr_sel[6:5]][state_q.arr_sel[4:0]] = pwdata[`MMU_PTE_V];
				end
				default: state_d.sr = state_d.sr;
			endcase
		end
		// Load-TLB sets its valid flag after any flush of the same cycle
		if (load_go) begin
			state_d.valid[mem_way][mem_idx] = state_q.page_entry_low_reg[`MMU_PTE_V];
		end

		// Classify the access
		for (int w = 3; w >= 0; w--) begin
			if (!way_valid[w]) begin
				lowest_free = 2'(w);
			end
		end
		if (!any_match) begin
			kind = mmu_pkg::exc_tlb_miss;
		end else if ((cpu_req.write && !hit_data.pr[0]) || (!privileged && !hit_data.pr[1])) begin
			kind = mmu_pkg::exc_protect;
		end else if (cpu_req.write && !hit_data.d) begin
			kind = mmu_pkg::exc_first_write;
		end

		// Answer to the core
		state_d.rsp.valid = cpu_req.valid;
		state_d.rsp.exc = mmu_pkg::exc_none;
		state_d.rsp.vector = 32'h00000000;
		state_d.rsp.paddr = cpu_req.vaddr;
		state_d.rsp.cacheable = 1'b1;
		if (cpu_req.valid && state_q.at) begin
			state_d.rsp.exc = kind;
			// Cache indexes with bits 11..4 and tags with 31..10 of this address
			state_d.rsp.paddr = hit_data.sz ? {hit_data.physical_page_number[21:2], cpu_req.vaddr[11:0]}
				: {hit_data.physical_page_number, cpu_req.vaddr[9:0]};
			state_d.rsp.cacheable = hit_data.c;
		end

		// Hardware exception sequence, taking priority over software writes
		if (cpu_req.valid && state_q.at && kind != mmu_pkg::exc_none) begin
			state_d.page_entry_high_reg[31:10] = cpu_req.vaddr[31:10];
			state_d.fault_address_reg = cpu_req.vaddr;
			state_d.saved_pc_reg = cpu_req.delay_slot ? cpu_req.branch_pc : cpu_req.pc;
			state_d.saved_status_reg = state_q.sr;
			state_d.sr[`MMU_SR_MD] = 1'b1;
			state_d.sr[`MMU_SR_BL] = 1'b1;
			state_d.sr[`MMU_SR_RB] = 1'b1;
			case (kind)
				mmu_pkg::exc_tlb_miss: begin
					state_d.exception_event_reg = cpu_req.write ? `MMU_CODE_MISS_ST : `MMU_CODE_MISS_LD;
					state_d.rc = (&way_valid) ? state_q.rc + 2'd1 : lowest_free;
					state_d.rsp.vector = state_q.vector_base_reg + `MMU_VEC_MISS;
				end
				mmu_pkg::exc_invalid: begin
					state_d.exception_event_reg = cpu_req.write ? `MMU_CODE_MISS_ST : `MMU_CODE_MISS_LD;
					state_d.rc = hit_way;
					state_d.rsp.vector = state_q.vector_base_reg + `MMU_VEC_OTHER;
				end
				mmu_pkg::exc_protect: begin
					state_d.exception_event_reg = cpu_req.write ? `MMU_CODE_PROT_ST : `MMU_CODE_PROT_LD;
					state_d.rc = hit_way;
					state_d.rsp.vector = state_q.vector_base_reg + `MMU_VEC_OTHER;
				end
				default: begin
					state_d.exception_event_reg = `MMU_CODE_FIRST_WR;
					state_d.rc = hit_way;
					state_d.rsp.vector = state_q.vector_base_reg + `MMU_VEC_OTHER;
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= '0;
			state_q.sr <= `MMU_SR_RESET;
		end else begin
			state_q <= state_d;
		end
	end

	// Outputs straight from the state flops
	assign prdata = state_q.prdata;
	assign pready = state_q.pready;
	assign pslverr = state_q.pslverr;
	assign cpu_rsp = state_q.rsp;
	assign status_reg = state_q.sr;

endmodule : mmu_tlb
`default_nettype wire

//--- dv/mmu_tlb_asserts.sv
// Port-level assertions for the MMU block, bound into its top module
`default_nettype none
module mmu_tlb_asserts (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic pready,
	input wire logic pslverr,
	input wire mmu_pkg::cpu_req_s cpu_req,
	input wire mmu_pkg::cpu_rsp_s cpu_rsp,
	input wire logic [31:0] status_reg
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// ----------------------------------------
	// Sequences of one translation
	// ----------------------------------------
	sequence s_req;
		cpu_req.valid;
	endsequence
	sequence s_clean;
		cpu_rsp.valid && cpu_rsp.exc == mmu_pkg::exc_none;
	endsequence
	sequence s_fault;
		cpu_rsp.valid && cpu_rsp.exc != mmu_pkg::exc_none;
	endsequence

	// ----------------------------------------
	// Bus and core handshakes
	// ----------------------------------------
	property p_ready_after_setup;
		psel && !penable |=> pready;
	endproperty
	property p_ready_in_access;
		pready |-> psel && penable;
	endproperty
	property p_err_with_ready;
		pslverr |-> pready;
	endproperty
	property p_rsp_follows;
		s_req |=> cpu_rsp.valid;
	endproperty
	property p_no_stray_rsp;
		!cpu_req.valid |=> !cpu_rsp.valid;
	endproperty
	// Page offset is never translated, 1-kbyte pages the smallest
	property p_offset_kept;
		s_req ##1 s_clean |-> cpu_rsp.paddr[9:0] == $past(cpu_req.vaddr[9:0]);
	endproperty
	property p_fault_flags;
		s_fault |-> status_reg[30:28] == 3'b111;
	endproperty
	property p_clean_vector;
		s_clean |-> cpu_rsp.vector == 32'h00000000;
	endproperty
	property p_kinds;
		cpu_rsp.valid |-> cpu_rsp.exc inside {mmu_pkg::exc_none, mmu_pkg::exc_tlb_miss,
			mmu_pkg::exc_protect, mmu_pkg::exc_invalid, mmu_pkg::exc_first_write};
	endproperty
	// Status moves only on a bus write or a core access
	property p_status_cause;
		!$stable(status_reg) |-> $past(psel && penable && pwrite) || $past(cpu_req.valid);
	endproperty

	a_ready_after_setup: assert property (p_ready_after_setup) else $error("no ready");
	a_ready_in_access: assert property (p_ready_in_access) else $error("stray ready");
	a_err_with_ready: assert property (p_err_with_ready) else $error("stray error");
	a_rsp_follows: assert property (p_rsp_follows) else $error("no answer");
	a_no_stray_rsp: assert property (p_no_stray_rsp) else $error("stray answer");
	a_offset_kept: assert property (p_offset_kept) else $error("offset moved");
	a_fault_flags: assert property (p_fault_flags) else $error("flags not set");
	a_clean_vector: assert property (p_clean_vector) else $error("vector set");
	a_kinds: assert property (p_kinds) else $error("bad kind");
	a_status_cause: assert property (p_status_cause) else $error("status moved");
endmodule : mmu_tlb_asserts

bind mmu_tlb mmu_tlb_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
	.cpu_req(cpu_req), .cpu_rsp(cpu_rsp), .status_reg(status_reg));
`default_nettype wire

//--- dv/cpu_core_model.sv
// Core-side model issuing one-cycle translation requests
`default_nettype none
module cpu_core_model (
	input wire logic pclk,
	output mmu_pkg::cpu_req_s req,
	input wire mmu_pkg::cpu_rsp_s rsp_in
);
	timeunit 1ns;
	timeprecision 1ps;
	initial req = '0;

	// One request, then fields scrambled so stale values never look valid
	task access(input logic w, input logic [31:0] va, input logic [31:0] pc,
		input logic ds, input logic [31:0] bpc, output mmu_pkg::cpu_rsp_s r);
		@(posedge pclk);
		req <= {1'b1, w, va, pc, ds, bpc};
		@(posedge pclk);
		req <= {1'b0, ~w, ~va, ~pc, ~ds, ~bpc};
		#1 r = rsp_in;
	endtask : access
endmodule : cpu_core_model
`default_nettype wire

//--- dv/testbench.sv
// Self-checking bench for the MMU block
`include "mmu_defines.svh"
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, status_reg, rd;
	mmu_pkg::cpu_req_s cpu_req;
	mmu_pkg::cpu_rsp_s cpu_rsp, rsp;
	int mismatches, n_compared;
	// Entry: page 0x12345, valid, full rights, cacheable, dirty
	localparam logic [31:0] ENTRY = 32'h048d156c;

	mmu_tlb dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cpu_req(cpu_req), .cpu_rsp(cpu_rsp), .status_reg(status_reg));
	cpu_core_model cpu (.pclk(pclk), .req(cpu_req), .rsp_in(cpu_rsp));

	always #20 pclk = ~pclk;

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task close_out;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : close_out

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			$display("wrong value %s expected %h seen %h", nm, e, g);
			mismatches++;
		end
	endtask : chk

	// Setup, access, hold until ready sampled high
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			mismatches++;
			close_out;
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(nm, e, rd);
	endtask : rdc

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_off;
		cpu.access(1'b0, 32'h12345678, 32'ha0000100, 1'b0, 32'h0, rsp);
		chk("off paddr", 32'h12345678, rsp.paddr);
		chk("off exc", mmu_pkg::exc_none, rsp.exc);
		chk("off cache", 32'h1, rsp.cacheable);
		$display("test untranslated done");
	endtask : t_off

	task t_miss;
		apb(1'b1, `MMU_OFF_VBR, 32'h80000000);
		apb(1'b1, `MMU_OFF_SR, 32'h0);
		apb(1'b1, `MMU_OFF_CTRL, 32'h1);
		cpu.access(1'b0, 32'h00003404, 32'h8c001000, 1'b0, 32'h0, rsp);
		chk("exc", mmu_pkg::exc_tlb_miss, rsp.exc);
		chk("vector", 32'h80000400, rsp.vector);
		chk("sr", 32'h70000000, status_reg);
		rdc("tea", `MMU_OFF_TEA, 32'h00003404);
		rdc("code", `MMU_OFF_EXCEPTION_EVENT_REG, 32'h040);
		rdc("spc", `MMU_OFF_SPC, 32'h8c001000);
		rdc("ssr", `MMU_OFF_SSR, 32'h0);
		rdc("page_entry_high_reg", `MMU_OFF_PAGE_ENTRY_HIGH_REG, 32'h00003400);
		rdc("ctrl", `MMU_OFF_CTRL, 32'h1);
		$display("test load miss done");
	endtask : t_miss

	task t_load;
		apb(1'b1, `MMU_OFF_PAGE_ENTRY_LOW_REG, ENTRY);
		apb(1'b1, `MMU_OFF_LOAD, 32'h1);
		repeat (2) @(posedge pclk);
		cpu.access(1'b0, 32'h00003404, 32'h8c001004, 1'b0, 32'h0, rsp);
		chk("hit exc", mmu_pkg::exc_none, rsp.exc);
		chk("hit paddr", 32'h048d1404, rsp.paddr);
		chk("cacheable", 32'h1, rsp.cacheable);
		// Same index, other page: way 0 now valid so way 1 is next
		cpu.access(1'b1, 32'h00103404, 32'h8c001008, 1'b1, 32'h8c001006, rsp);
		chk("st exc", mmu_pkg::exc_tlb_miss, rsp.exc);
		rdc("st code", `MMU_OFF_EXCEPTION_EVENT_REG, 32'h060);
		rdc("st spc", `MMU_OFF_SPC, 32'h8c001006);
		rdc("st ssr", `MMU_OFF_SSR, 32'h70000000);
		rdc("st rc", `MMU_OFF_CTRL, 32'h11);
		$display("test load and second miss done");
	endtask : t_load

	task t_hash;
		apb(1'b1, `MMU_OFF_CTRL, 32'h7);
		rdc("flush bit", `MMU_OFF_CTRL, 32'h3);
		apb(1'b1, `MMU_OFF_PAGE_ENTRY_HIGH_REG, 32'h00003405);
		apb(1'b1, `MMU_OFF_PAGE_ENTRY_LOW_REG, ENTRY);
		apb(1'b1, `MMU_OFF_LOAD, 32'h1);
		apb(1'b1, `MMU_OFF_ARR_SEL, 32'h06);
		rdc("hashed slot", `MMU_OFF_ARR_ADDR, 32'h00003505);
		apb(1'b1, `MMU_OFF_ARR_SEL, 32'h03);
		rdc("flushed slot", `MMU_OFF_ARR_ADDR, 32'h00003400);
		repeat (2) @(posedge pclk);
		cpu.access(1'b0, 32'h00003404, 32'h8c00100c, 1'b0, 32'h0, rsp);
		chk("hash hit", mmu_pkg::exc_none, rsp.exc);
		$display("test hashed index done");
	endtask : t_hash

	// User store to a user read-only page; way counter moved off first
	task t_prot;
		apb(1'b1, `MMU_OFF_PAGE_ENTRY_LOW_REG, 32'h048d154c);
		apb(1'b1, `MMU_OFF_LOAD, 32'h1);
		apb(1'b1, `MMU_OFF_CTRL, 32'h23);
		apb(1'b1, `MMU_OFF_SR, 32'h0);
		repeat (2) @(posedge pclk);
		cpu.access(1'b1, 32'h00003404, 32'h8c001010, 1'b0, 32'h0, rsp);
		chk("prot exc", mmu_pkg::exc_protect, rsp.exc);
		chk("prot vector", 32'h80000100, rsp.vector);
		rdc("prot code", `MMU_OFF_EXCEPTION_EVENT_REG, 32'h0c0);
		rdc("prot rc", `MMU_OFF_CTRL, 32'h3);
		rdc("prot ssr", `MMU_OFF_SSR, 32'h0);
		$display("test protection done");
	endtask : t_prot

	task t_err;
		apb(1'b0, 8'hfc, 32'h0);
		chk("err flag", 32'h1, er);
		chk("err data", 32'h0, rd);
		$display("test unmapped done");
	endtask : t_err

	// ----------------------------------------
	// Main sequence and hang guard
	// ----------------------------------------
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		rdc("reset sr", `MMU_OFF_SR, 32'h70000000);
		rdc("reset ctrl", `MMU_OFF_CTRL, 32'h0);
		t_off();
		t_miss();
		t_load();
		t_hash();
		t_prot();
		t_err();
		close_out();
	end

	initial begin
		repeat (5000) @(posedge pclk);
		$display("run timed out");
		mismatches++;
		close_out();
	end
endmodule : testbench
`default_nettype wire
